/* File: inc/dsrl_cfg.svh */
// Purpose: Constants for the serial register loader
// Assumes: Included by its bare name
// Notes:   Offsets are bit positions inside the 16-bit command word
`ifndef DSRL_CFG_SVH
`define DSRL_CFG_SVH

`define DSRL_WORD_W        16
`define DSRL_CNT_W         5
`define DSRL_BITS_PER_WORD 5'h10
`define DSRL_LAST_BIT      5'h0F
`define DSRL_FREQ_W        32
`define DSRL_HALF_W        16
`define DSRL_PHASE_W       12
`define DSRL_PSEL_LO_BIT   9
`define DSRL_PSEL_HI_BIT   10
`define DSRL_FSEL_BIT      11
`define DSRL_CLR_BIT       11
`define DSRL_SELECT_SOURCE_BIT    12
`define DSRL_FREQ_RST      32'h0000_0000
`define DSRL_PHASE_RST     12'h000
`define DSRL_HALF_RST      16'h0000

`endif

/* File: inc/dsrl_pkg.sv */
// Purpose: Types for the serial register loader
// Assumes: Nothing
// Notes:   Command codes are the top nibble of each word
package dsrl_pkg;

    typedef enum logic [3:0] {
        DSRL_CMD_PHASE_DIRECT = 4'b0000,
        DSRL_CMD_PHASE_DEFER  = 4'b0001,
        DSRL_CMD_FREQ_DIRECT  = 4'b0010,
        DSRL_CMD_FREQ_DEFER   = 4'b0011,
        DSRL_CMD_PSEL         = 4'b0100,
        DSRL_CMD_FSEL         = 4'b0101,
        DSRL_CMD_BOTH_SEL     = 4'b0110,
        DSRL_CMD_TEST         = 4'b0111
    } dsrl_cmd_t;

    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [7:0] data;
    } dsrl_word_t;

    typedef struct packed {
        logic phase_hi;
        logic phase_lo;
        logic freq;
    } dsrl_sel_t;

endpackage

/* File: rtl/dsrl_loader.sv */
// Purpose: Serial command interpreter loading frequency and phase registers
// Assumes: serial_clk is the link clock; clk is the master clock
// Notes:   Word handed across by toggle; word held stable until next full frame
`timescale 1ns/1ps
`include "dsrl_cfg.svh"

module dsrl_loader (
    input  wire logic                           clk,
    input  wire logic                           nrst,
    input  wire logic                           serial_clk,
    input  wire logic                           frame_sync_n,
    input  wire logic                           serial_data_in,
    input  wire logic                           frequency_select,
    input  wire logic                           phase_select_lo,
    input  wire logic                           phase_select_hi,
    output logic      [`DSRL_FREQ_W-1:0]        freq_word_0,
    output logic      [`DSRL_FREQ_W-1:0]        freq_word_1,
    output logic      [`DSRL_PHASE_W-1:0]       phase_offset_0,
    output logic      [`DSRL_PHASE_W-1:0]       phase_offset_1,
    output logic      [`DSRL_PHASE_W-1:0]       phase_offset_2,
    output logic      [`DSRL_PHASE_W-1:0]       phase_offset_3,
    output logic      [`DSRL_FREQ_W-1:0]        phase_step,
    output logic      [`DSRL_PHASE_W-1:0]       phase_offset_sel,
    output dsrl_pkg::dsrl_sel_t                 select_active,
    output logic                                select_source
);
    import dsrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Both write commands, direct and deferred, sit in the 00xx group
    function automatic logic cmd_is_write(
        input logic [3:0] cmd
    );
        cmd_is_write = cmd[3:2] == 2'b00;
    endfunction

    // Direct commands copy the defer word into the data register
    function automatic logic cmd_is_direct(
        input logic [3:0] cmd
    );
        cmd_is_direct = cmd == DSRL_CMD_PHASE_DIRECT || cmd == DSRL_CMD_FREQ_DIRECT;
    endfunction

    // Phase commands need addresses 8-15, frequency commands 0-7
    function automatic logic cmd_addr_ok(
        input logic [3:0] cmd,
        input logic [3:0] addr
    );
        cmd_addr_ok = (cmd[1] == 1'b0) == addr[3];
    endfunction

    // Commands that carry the phase select bits
    function automatic logic cmd_sets_psel(
        input logic [3:0] cmd
    );
        cmd_sets_psel = cmd == DSRL_CMD_PSEL || cmd == DSRL_CMD_BOTH_SEL;
    endfunction

    // Commands that carry the frequency select bit
    function automatic logic cmd_sets_fsel(
        input logic [3:0] cmd
    );
        cmd_sets_fsel = cmd == DSRL_CMD_FSEL || cmd == DSRL_CMD_BOTH_SEL;
    endfunction

    // Source command group 10xx
    function automatic logic cmd_is_source(
        input logic [3:0] cmd
    );
        cmd_is_source = cmd[3:2] == 2'b10;
    endfunction

    // Control command group 11xx
    function automatic logic cmd_is_control(
        input logic [3:0] cmd
    );
        cmd_is_control = cmd[3:2] == 2'b11;
    endfunction

    // Pending load aimed at frequency register idx
    function automatic logic freq_hit(
        input logic [3:0] addr,
        input logic       idx
    );
        freq_hit = !addr[3] && addr[2] == idx;
    endfunction

    // Pending load aimed at phase register idx
    function automatic logic phase_hit(
        input logic [3:0] addr,
        input logic [1:0] idx
    );
        phase_hit = addr[3] && addr[2:1] == idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link side, falling edges of serial_clk

    logic [`DSRL_CNT_W-1:0]  bit_cnt_q;
    logic [`DSRL_WORD_W-1:0] shift_q;
    dsrl_word_t              link_word_q;
    logic                    link_tog_q;

    // Count is held clear while frame sync is high, so a short frame is dropped
    always_ff @(negedge serial_clk or negedge nrst or posedge frame_sync_n) begin
        if (!nrst) begin
            bit_cnt_q <= '0;
        end else if (frame_sync_n) begin
            bit_cnt_q <= '0;
        end else if (bit_cnt_q != `DSRL_BITS_PER_WORD) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // MSB first shift
    always_ff @(negedge serial_clk or negedge nrst) begin
        if (!nrst) begin
            shift_q <= '0;
        end else if (!frame_sync_n) begin
            shift_q <= {shift_q[`DSRL_WORD_W-2:0], serial_data_in};
        end
    end

    // Sixteenth edge hands the whole word over
    always_ff @(negedge serial_clk or negedge nrst) begin
        if (!nrst) begin
            link_word_q <= '0;
            link_tog_q  <= 1'b0;
        end else if (!frame_sync_n && bit_cnt_q == `DSRL_LAST_BIT) begin
            link_word_q <= {shift_q[`DSRL_WORD_W-2:0], serial_data_in};
            link_tog_q  <= ~link_tog_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossing into clk domain

    logic       tog_s1_q;
    logic       tog_s2_q;
    logic       tog_s3_q;
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            tog_s1_q <= link_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {phase_select_hi, phase_select_lo, frequency_select};
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word capture

    logic       word_v_q;
    dsrl_word_t word_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            word_v_q <= 1'b0;
            word_q   <= '0;
        end else begin
            word_v_q <= tog_s2_q ^ tog_s3_q;
            if (tog_s2_q ^ tog_s3_q) begin
                word_q <= link_word_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Defer and data registers

    function automatic logic [`DSRL_HALF_W-1:0] merge_byte(
        input logic [`DSRL_HALF_W-1:0] half,
        input logic                    upper,
        input logic [7:0]              data
    );
        merge_byte = upper ? {data, half[7:0]} : {half[15:8], data};
    endfunction

    logic [`DSRL_HALF_W-1:0] defer_q;
    logic [`DSRL_HALF_W-1:0] data_q;
    logic                    load_pend_q;
    logic [3:0]              load_addr_q;
    logic                    is_write;
    logic                    is_direct;
    logic                    addr_ok;

    always_comb begin
        is_write  = cmd_is_write(word_q.cmd);
        is_direct = cmd_is_direct(word_q.cmd);
        addr_ok   = cmd_addr_ok(word_q.cmd, word_q.addr);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            defer_q <= `DSRL_HALF_RST;
        end else if (word_v_q && is_write) begin
            defer_q <= merge_byte(defer_q, word_q.addr[0], word_q.data);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_q      <= `DSRL_HALF_RST;
            load_pend_q <= 1'b0;
            load_addr_q <= '0;
        end else begin
            load_pend_q <= word_v_q && is_direct && addr_ok;
            if (word_v_q && is_direct && addr_ok) begin
                data_q      <= merge_byte(defer_q, word_q.addr[0], word_q.data);
                load_addr_q <= word_q.addr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Destination registers

    logic [`DSRL_FREQ_W-1:0]  freq_q [2];
    logic [`DSRL_PHASE_W-1:0] phase_q [4];

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_freq
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    freq_q[gi] <= `DSRL_FREQ_RST;
                end else if (load_pend_q && freq_hit(load_addr_q, 1'(gi))) begin
                    if (load_addr_q[1]) begin
                        freq_q[gi][31:16] <= data_q;
                    end else begin
                        freq_q[gi][15:0] <= data_q;
                    end
                end
            end
        end
        for (gi = 0; gi < 4; gi++) begin : g_phase
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    phase_q[gi] <= `DSRL_PHASE_RST;
                end else if (load_pend_q && phase_hit(load_addr_q, 2'(gi))) begin
                    phase_q[gi] <= data_q[`DSRL_PHASE_W-1:0];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Select bits and select source

    dsrl_sel_t sel_bits_q;
    logic      sel_src_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_bits_q <= '0;
        end else if (word_v_q) begin
            if (cmd_sets_psel(word_q.cmd)) begin
                sel_bits_q.phase_lo <= word_q[`DSRL_PSEL_LO_BIT];
                sel_bits_q.phase_hi <= word_q[`DSRL_PSEL_HI_BIT];
            end
            if (cmd_sets_fsel(word_q.cmd)) begin
                sel_bits_q.freq <= word_q[`DSRL_FSEL_BIT];
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_src_q <= 1'b0;
        end else if (word_v_q && cmd_is_source(word_q.cmd)) begin
            sel_src_q <= word_q[`DSRL_SELECT_SOURCE_BIT];
        end else if (word_v_q && cmd_is_control(word_q.cmd) && word_q[`DSRL_CLR_BIT]) begin
            sel_src_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Selected outputs

    dsrl_sel_t               sel_eff;
    dsrl_sel_t               sel_q;
    logic [`DSRL_FREQ_W-1:0]  step_q;
    logic [`DSRL_PHASE_W-1:0] poff_q;

    always_comb begin
        sel_eff = sel_src_q ? sel_bits_q : dsrl_sel_t'(pin_s2_q);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_q  <= '0;
            step_q <= `DSRL_FREQ_RST;
            poff_q <= `DSRL_PHASE_RST;
        end else begin
            sel_q  <= sel_eff;
            step_q <= sel_eff.freq ? freq_q[1] : freq_q[0];
            poff_q <= phase_q[{sel_eff.phase_hi, sel_eff.phase_lo}];
        end
    end

    assign freq_word_0      = freq_q[0];
    assign freq_word_1      = freq_q[1];
    assign phase_offset_0   = phase_q[0];
    assign phase_offset_1   = phase_q[1];
    assign phase_offset_2   = phase_q[2];
    assign phase_offset_3   = phase_q[3];
    assign phase_step       = step_q;
    assign phase_offset_sel = poff_q;
    assign select_active    = sel_q;
    assign select_source    = sel_src_q;

endmodule

/* File: sim/dsrl_ctrl_model.sv */
// Purpose: Serial controller driving framed command words
// Assumes: Link clock of 48 ns, toggling inside frames and parked at a per-word idle level outside them
// Notes:   Data line shows the inverse of the last bit when released
`timescale 1ns/1ps
module dsrl_ctrl_model (
    output logic serial_clk,
    output logic frame_sync_n,
    output logic serial_data_in
);
    initial begin
        serial_clk = 1'b0;
        frame_sync_n = 1'b1;
        serial_data_in = 1'b0;
    end
    task automatic send_word(input logic [15:0] w, input int nbits, input logic idle);
        serial_clk = idle;
        #11;
        frame_sync_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            serial_clk = 1'b1;
            serial_data_in = w[15 - i];
            #24;
            serial_clk = 1'b0;
            #24;
        end
        frame_sync_n = 1'b1;
        serial_data_in = ~serial_data_in;
        serial_clk = idle;
    endtask
endmodule

/* File: sim/dsrl_loader_sva.sv */
// Purpose: Port assertions for the serial register loader
// Assumes: Bound to dsrl_loader, master clock domain only
// Notes:   Settled-value checks tolerate either output pipeline depth
`timescale 1ns/1ps
`include "dsrl_cfg.svh"
module dsrl_loader_sva (
    input logic                      clk,
    input logic                      nrst,
    input logic                      frame_sync_n,
    input logic                      frequency_select,
    input logic                      phase_select_lo,
    input logic                      phase_select_hi,
    input logic [`DSRL_FREQ_W-1:0]   freq_word_0,
    input logic [`DSRL_FREQ_W-1:0]   freq_word_1,
    input logic [`DSRL_PHASE_W-1:0]  phase_offset_0,
    input logic [`DSRL_PHASE_W-1:0]  phase_offset_1,
    input logic [`DSRL_PHASE_W-1:0]  phase_offset_2,
    input logic [`DSRL_PHASE_W-1:0]  phase_offset_3,
    input logic [`DSRL_FREQ_W-1:0]   phase_step,
    input logic [`DSRL_PHASE_W-1:0]  phase_offset_sel,
    input dsrl_pkg::dsrl_sel_t       select_active,
    input logic                      select_source
);
    import dsrl_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [2:0]               pins;
    logic [`DSRL_PHASE_W-1:0] offs [4];
    assign pins = {phase_select_hi, phase_select_lo, frequency_select};
    assign offs = '{phase_offset_0, phase_offset_1, phase_offset_2, phase_offset_3};
    ////////////////////////////////////////////////////////////////
    sequence s_fsteady; $stable(select_active) && $stable(freq_word_0) && $stable(freq_word_1); endsequence
    sequence s_psteady; $stable(select_active) && $stable(offs[0]) && $stable(offs[1]) && $stable(offs[2]) && $stable(offs[3]); endsequence
    property p_step; s_fsteady ##1 s_fsteady |-> phase_step == (select_active.freq ? freq_word_1 : freq_word_0); endproperty
    property p_offset; s_psteady ##1 s_psteady |-> phase_offset_sel == offs[{select_active.phase_hi, select_active.phase_lo}]; endproperty
    property p_pins; (!select_source && $stable(pins))[*4] |-> select_active == pins; endproperty
    property p_hold; (select_source && frame_sync_n)[*8] |=> $stable(select_active); endproperty
    property p_quiet; frame_sync_n[*8] |=> $stable({freq_word_0, freq_word_1, offs[0], offs[1], offs[2], offs[3], select_source}); endproperty
    property p_half0; !($changed(freq_word_0[31:16]) && $changed(freq_word_0[15:0])); endproperty
    property p_half1; !($changed(freq_word_1[31:16]) && $changed(freq_word_1[15:0])); endproperty
    property p_one; $countones({$changed(freq_word_0), $changed(freq_word_1), $changed(offs[0]), $changed(offs[1]), $changed(offs[2]), $changed(offs[3])}) <= 1; endproperty
    ////////////////////////////////////////////////////////////////
    a_step: assert property (p_step) else $error("phase step wrong");
    a_offset: assert property (p_offset) else $error("phase offset wrong");
    a_pins: assert property (p_pins) else $error("pins not followed");
    a_hold: assert property (p_hold) else $error("internal select moved");
    a_quiet: assert property (p_quiet) else $error("update without frame");
    a_half0: assert property (p_half0) else $error("both halves moved");
    a_half1: assert property (p_half1) else $error("both halves moved");
    a_one: assert property (p_one) else $error("several loads at once");
endmodule
bind dsrl_loader dsrl_loader_sva u_sva (.clk(clk), .nrst(nrst), .frame_sync_n(frame_sync_n),
    .frequency_select(frequency_select), .phase_select_lo(phase_select_lo), .phase_select_hi(phase_select_hi),
    .freq_word_0(freq_word_0), .freq_word_1(freq_word_1), .phase_offset_0(phase_offset_0),
    .phase_offset_1(phase_offset_1), .phase_offset_2(phase_offset_2), .phase_offset_3(phase_offset_3),
    .phase_step(phase_step), .phase_offset_sel(phase_offset_sel), .select_active(select_active),
    .select_source(select_source));

/* File: sim/tb_dsrl_loader.sv */
// Purpose: Self-checking bench for the serial register loader
// Assumes: Expected registers kept by a reference model in the bench
// Notes:   All six registers and selections compared after every frame
`timescale 1ns/1ps
`include "dsrl_cfg.svh"
module tb_dsrl_loader;
    import dsrl_pkg::*;
    logic        clk, nrst, serial_clk, frame_sync_n, serial_data_in;
    logic        frequency_select, phase_select_lo, phase_select_hi, select_source, esrc;
    logic [31:0] freq_word_0, freq_word_1, phase_step, efw [2];
    logic [11:0] phase_offset_0, phase_offset_1, phase_offset_2, phase_offset_3, phase_offset_sel, eph [4];
    logic [15:0] edef;
    dsrl_sel_t   select_active, eint;
    int          err_count = 0, samples_checked = 0, cycles = 0, p;
    dsrl_loader u_dut (.clk(clk), .nrst(nrst), .serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
        .serial_data_in(serial_data_in), .frequency_select(frequency_select), .phase_select_lo(phase_select_lo),
        .phase_select_hi(phase_select_hi), .freq_word_0(freq_word_0), .freq_word_1(freq_word_1),
        .phase_offset_0(phase_offset_0), .phase_offset_1(phase_offset_1), .phase_offset_2(phase_offset_2),
        .phase_offset_3(phase_offset_3), .phase_step(phase_step), .phase_offset_sel(phase_offset_sel),
        .select_active(select_active), .select_source(select_source));
    dsrl_ctrl_model u_ctrl (.serial_clk(serial_clk), .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task complete_run;
        $display("Checks %0d, errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task check_all;
        dsrl_sel_t es;
        #1;
        es = esrc ? eint : dsrl_sel_t'({phase_select_hi, phase_select_lo, frequency_select});
        check(freq_word_0, efw[0]);
        check(freq_word_1, efw[1]);
        check(32'(phase_offset_0), 32'(eph[0]));
        check(32'(phase_offset_1), 32'(eph[1]));
        check(32'(phase_offset_2), 32'(eph[2]));
        check(32'(phase_offset_3), 32'(eph[3]));
        check(32'(select_source), 32'(esrc));
        check(32'(select_active), 32'(es));
        check(phase_step, efw[es.freq]);
        check(32'(phase_offset_sel), 32'(eph[{es.phase_hi, es.phase_lo}]));
    endtask
    task wr(input logic [3:0] c, input logic [3:0] a, input logic [7:0] d, input int n, input logic idle);
        logic [15:0] w;
        w = {c, a, d};
        u_ctrl.send_word(w, n, idle);
        repeat (12) @(posedge clk);
        if (n == 16) begin
            if (c < 4'h4 && a[0]) edef[15:8] = d;
            if (c < 4'h4 && !a[0]) edef[7:0] = d;
            if (c == 4'h0 && a[3]) eph[a[2:1]] = edef[11:0];
            if (c == 4'h2 && !a[3] && a[1]) efw[a[2]][31:16] = edef;
            if (c == 4'h2 && !a[3] && !a[1]) efw[a[2]][15:0] = edef;
            if (c == 4'h4 || c == 4'h6) {eint.phase_hi, eint.phase_lo} = w[10:9];
            if (c == 4'h5 || c == 4'h6) eint.freq = w[11];
            if (c[3:2] == 2'b10) esrc = w[12];
            if (c[3:2] == 2'b11 && w[11]) esrc = 1'b0;
        end
        check_all();
    endtask
    task pins(input logic [2:0] v);
        @(posedge clk);
        {phase_select_hi, phase_select_lo, frequency_select} <= v;
        repeat (8) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        {phase_select_hi, phase_select_lo, frequency_select} = 3'h0;
        efw = '{default: 32'h0};
        eph = '{default: 12'h0};
        edef = 16'h0;
        eint = '0;
        esrc = 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        check_all();
        wr(4'h3, 4'h0, 8'h11, 16, 1'b0);
        wr(4'h2, 4'h1, 8'h22, 16, 1'b0);
        wr(4'h3, 4'h2, 8'h33, 16, 1'b1);
        wr(4'h2, 4'h3, 8'h44, 16, 1'b1);
        wr(4'h2, 4'h1, 8'h55, 16, 1'b0);
        for (p = 4; p < 8; p++) wr(4'h2, p[3:0], 8'hA0 + p[7:0], 16, p[0]);
        for (p = 0; p < 4; p++) begin
            wr(4'h1, 4'(9 + 2 * p), p[7:0], 16, 1'b0);
            wr(4'h0, 4'(8 + 2 * p), 8'hC0 + p[7:0], 16, 1'b1);
        end
        wr(4'h0, 4'h2, 8'h77, 16, 1'b0);
        wr(4'h2, 4'h9, 8'h66, 16, 1'b0);
        for (p = 0; p < 8; p++) begin
            pins(p[2:0]);
            check_all();
        end
        wr(4'h9, 4'h0, 8'h00, 16, 1'b0);
        pins(3'h0);
        wr(4'h4, 4'h6, 8'h00, 16, 1'b1);
        wr(4'h5, 4'h8, 8'h00, 16, 1'b0);
        wr(4'h6, 4'h2, 8'h00, 16, 1'b1);
        pins(3'h7);
        wr(4'h7, 4'hF, 8'hFF, 16, 1'b0);
        wr(4'h2, 4'h1, 8'h99, 10, 1'b0);
        wr(4'hC, 4'h8, 8'h00, 16, 1'b1);
        complete_run();
    end
endmodule
